// >>> inc/gsrb_pkg.sv
// package: register map, field positions and reset values of the gas sensor register bank
package gsrb_pkg;
   localparam logic [7:0] ADDR_PRODUCT_REVISION_ID     = 8'h00;
   localparam logic [7:0] ADDR_SENSOR_STATUS    = 8'h01;
   localparam logic [7:0] ADDR_PERIOD_H    = 8'h02;
   localparam logic [7:0] ADDR_PERIOD_L    = 8'h03;
   localparam logic [7:0] ADDR_MEASUREMENT_CONFIG    = 8'h04;
   localparam logic [7:0] ADDR_CONC_H      = 8'h05;
   localparam logic [7:0] ADDR_CONC_L      = 8'h06;
   localparam logic [7:0] ADDR_MEASUREMENT_STATUS    = 8'h07;
   localparam logic [7:0] ADDR_INT_CFG     = 8'h08;
   localparam logic [7:0] ADDR_ALARM_H     = 8'h09;
   localparam logic [7:0] ADDR_ALARM_L     = 8'h0a;
   localparam logic [7:0] ADDR_PRES_H      = 8'h0b;
   localparam logic [7:0] ADDR_PRES_L      = 8'h0c;
   localparam logic [7:0] ADDR_BASE_H      = 8'h0d;
   localparam logic [7:0] ADDR_BASE_L      = 8'h0e;
   localparam logic [7:0] ADDR_SCRATCH     = 8'h0f;
   localparam logic [7:0] ADDR_SOFT_RST    = 8'h10;
   localparam logic [7:0] ADDR_ERR_FIRST   = 8'h11;
   localparam logic [7:0] ADDR_ERR_LAST    = 8'h14;
   localparam int         NUM_REGS         = 17;
   // identity value is arbitrary
   localparam logic [7:0] RST_PRODUCT_REVISION_ID      = 8'h5a;
   localparam logic [7:0] RST_SENSOR_STATUS     = 8'hc0;
   localparam logic [7:0] RST_PERIOD_L     = 8'h3c;
   localparam logic [7:0] RST_MEASUREMENT_CONFIG     = 8'h24;
   localparam logic [7:0] RST_PRES_H       = 8'h03;
   localparam logic [7:0] RST_PRES_L       = 8'hf7;
   localparam logic [7:0] RST_BASE_H       = 8'h01;
   localparam logic [7:0] RST_BASE_L       = 8'h90;
   localparam logic [7:0] RST_ZERO         = 8'h00;
   // sensor status bit positions
   localparam int BIT_INIT     = 7;
   localparam int BIT_PIN      = 6;
   localparam int BIT_TEMP_ERR = 5;
   localparam int BIT_SUP_ERR  = 4;
   localparam int BIT_COMM_ERR = 3;
   localparam int BIT_TEMP_CLR = 2;
   localparam int BIT_SUP_CLR  = 1;
   localparam int BIT_COMM_CLR = 0;
   // masks of implemented bits; zeros read as zero and ignore writes
   localparam logic [7:0] MASK_PERIOD_H    = 8'h0f;
   localparam logic [7:0] MASK_MEASUREMENT_CONFIG    = 8'h3f;
   localparam logic [7:0] MASK_INT_CFG     = 8'h1f;
   // measurement status bits that survive a host write
   localparam logic [7:0] MASK_MEAS_KEEP   = 8'h1c;
   // controller registers on AXI4-Lite
   localparam logic [7:0] CSR_CMD          = 8'h00;
   localparam logic [7:0] CSR_WDATA        = 8'h04;
   localparam logic [7:0] CSR_RESULT       = 8'h08;
   localparam logic [7:0] CSR_IRQ_STS      = 8'h0c;
   localparam logic [7:0] CSR_IRQ_CLR      = 8'h10;
   localparam logic [7:0] CSR_IRQ_EN       = 8'h14;
   localparam int         CMD_WRITE_BIT    = 8;
   localparam int         CMD_GO_BIT       = 9;
   localparam int         RES_BUSY_BIT     = 8;
   localparam int         RES_ERR_BIT      = 9;
   localparam int         RES_NACK_BIT     = 10;
   // status answer of one access
   typedef enum logic [1:0] {GSRB_RSP_OK = 2'b00, GSRB_RSP_ERR = 2'b01,
                             GSRB_RSP_NACK = 2'b10} gsrb_rsp_t;
endpackage : gsrb_pkg

// >>> inc/gsrb_if.sv
// interface: byte access link between controller and register bank
`timescale 1ns/1ns
`default_nettype none
interface gsrb_if;
   logic       req;
   logic       wr;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       ack;
   logic [7:0] rdata;
   logic [1:0] rsp;
   modport dev  (input req, wr, addr, wdata, output ack, rdata, rsp);
   modport host (output req, wr, addr, wdata, input ack, rdata, rsp);
endinterface : gsrb_if
`default_nettype wire

// >>> src/gsrb_device.sv
// register bank of the gas sensor: byte access, access classes, error answers
// Contract
// - every access targets one byte register
// - read-only fields read back, ignore writes
// - write-only fields accept writes, read zero
// - rw hardware fields writable, hardware may update
// - hardware read-only fields change only internally
// - sticky bits stay set until reset or a write of their clear bit
// - unimplemented bits read zero, ignore writes
// - host writes zero into unimplemented bits
// - host writes only legal field encodings
// - addresses 0x11-0x14 give communication error
// - addresses 0x15-0xFF give non-acknowledge
// - reset loads printed default values
// - invalid command sets sticky comm error
// - clear bit clears flag, reads zero
`timescale 1ns/1ns
`default_nettype none
module gsrb_device (
   // clock and reset
   input  wire logic           i_core_clk,
   input  wire logic           i_rst_b,
   // link to controller
   gsrb_if.dev                 link,
   // sensor side events and values
   input  wire logic           i_pin_level,
   input  wire logic           i_init_done,
   input  wire logic           i_temp_err,
   input  wire logic           i_sup_err,
   input  wire logic           i_result_valid,
   input  wire logic [15:0]    i_result,
   input  wire logic           i_cfg_wr,
   input  wire logic [7:0]     i_cfg_value,
   // configuration towards the sensor core
   output logic [7:0]          o_measurement_config,
   output logic [15:0]         o_period,
   output logic [7:0]          o_soft_reset_code,
   output logic                o_soft_reset_stb
);
   import gsrb_pkg::*;

   typedef logic [NUM_REGS-1:0][7:0] gsrb_bank_t;

   typedef struct packed {
      gsrb_bank_t               regs;
      logic                     pin_s1;
      logic                     pin_s2;
      logic                     ack;
      logic [7:0]               rdata;
      logic [1:0]               rsp;
      logic [7:0]               srst;
      logic                     srst_stb;
   } gsrb_dev_t;

   gsrb_dev_t st_reg, st_next;

   function automatic logic [7:0] wmask(input logic [7:0] a);
      case (a)
         ADDR_PERIOD_H: wmask = MASK_PERIOD_H;
         ADDR_MEASUREMENT_CONFIG: wmask = MASK_MEASUREMENT_CONFIG;
         ADDR_INT_CFG:  wmask = MASK_INT_CFG;
         default:       wmask = 8'hff;
      endcase
   endfunction : wmask

   // printed defaults, every other byte starts at zero
   function automatic gsrb_bank_t reset_bank();
      gsrb_bank_t b;
      b                = '0;
      b[ADDR_PRODUCT_REVISION_ID]  = RST_PRODUCT_REVISION_ID;
      b[ADDR_SENSOR_STATUS] = RST_SENSOR_STATUS;
      b[ADDR_PERIOD_L] = RST_PERIOD_L;
      b[ADDR_MEASUREMENT_CONFIG] = RST_MEASUREMENT_CONFIG;
      b[ADDR_PRES_H]   = RST_PRES_H;
      b[ADDR_PRES_L]   = RST_PRES_L;
      b[ADDR_BASE_H]   = RST_BASE_H;
      b[ADDR_BASE_L]   = RST_BASE_L;
      return b;
   endfunction : reset_bank

   // all eight address bits decoded, no byte answers twice
   function automatic logic [7:0] read_byte(input gsrb_bank_t b, input logic [7:0] a);
      case (a)
         ADDR_PRODUCT_REVISION_ID:  read_byte = b[ADDR_PRODUCT_REVISION_ID];
         ADDR_SENSOR_STATUS: read_byte = b[ADDR_SENSOR_STATUS];
         ADDR_PERIOD_H: read_byte = b[ADDR_PERIOD_H];
         ADDR_PERIOD_L: read_byte = b[ADDR_PERIOD_L];
         ADDR_MEASUREMENT_CONFIG: read_byte = b[ADDR_MEASUREMENT_CONFIG];
         ADDR_CONC_H:   read_byte = b[ADDR_CONC_H];
         ADDR_CONC_L:   read_byte = b[ADDR_CONC_L];
         ADDR_MEASUREMENT_STATUS: read_byte = b[ADDR_MEASUREMENT_STATUS];
         ADDR_INT_CFG:  read_byte = b[ADDR_INT_CFG];
         ADDR_ALARM_H:  read_byte = b[ADDR_ALARM_H];
         ADDR_ALARM_L:  read_byte = b[ADDR_ALARM_L];
         ADDR_PRES_H:   read_byte = b[ADDR_PRES_H];
         ADDR_PRES_L:   read_byte = b[ADDR_PRES_L];
         ADDR_BASE_H:   read_byte = b[ADDR_BASE_H];
         ADDR_BASE_L:   read_byte = b[ADDR_BASE_L];
         ADDR_SCRATCH:  read_byte = b[ADDR_SCRATCH];
         ADDR_SOFT_RST: read_byte = RST_ZERO;
         default:       read_byte = RST_ZERO;
      endcase
   endfunction : read_byte

   function automatic logic in_err_window(input logic [7:0] a);
      in_err_window = (a >= ADDR_ERR_FIRST) && (a <= ADDR_ERR_LAST);
   endfunction : in_err_window
   function automatic logic in_nack_window(input logic [7:0] a);
      in_nack_window = (a > ADDR_ERR_LAST);
   endfunction : in_nack_window

   logic [7:0] sts;
   logic       is_err, is_nack, wr_hit;

   ////////////////////////////////////////////////////////////////
   always_comb begin
      st_next          = st_reg;
      st_next.ack      = 1'b0;
      st_next.srst_stb = 1'b0;
      // pin crosses in through two flops
      st_next.pin_s1   = i_pin_level;
      st_next.pin_s2   = st_reg.pin_s1;
      is_err  = in_err_window(link.addr);
      is_nack = in_nack_window(link.addr);
      wr_hit  = link.req && !st_reg.ack && link.wr && !is_err && !is_nack;
      sts     = st_reg.regs[ADDR_SENSOR_STATUS];
      sts[BIT_PIN]  = st_reg.pin_s2;
      sts[BIT_INIT] = sts[BIT_INIT] | i_init_done;
      // clear bits act before new events so a same-cycle event wins
      if (wr_hit && link.addr == ADDR_SENSOR_STATUS) begin
         if (link.wdata[BIT_TEMP_CLR]) sts[BIT_TEMP_ERR] = 1'b0;
         if (link.wdata[BIT_SUP_CLR])  sts[BIT_SUP_ERR]  = 1'b0;
         if (link.wdata[BIT_COMM_CLR]) sts[BIT_COMM_ERR] = 1'b0;
      end
      // error flags only set by hardware
      if (i_temp_err) sts[BIT_TEMP_ERR] = 1'b1;
      if (i_sup_err)  sts[BIT_SUP_ERR]  = 1'b1;
      if (link.req && !st_reg.ack && is_err) sts[BIT_COMM_ERR] = 1'b1;
      sts[2:0] = 3'b000;
      st_next.regs[ADDR_SENSOR_STATUS] = sts;
      if (i_cfg_wr) st_next.regs[ADDR_MEASUREMENT_CONFIG] = i_cfg_value & MASK_MEASUREMENT_CONFIG;
      // result registers loaded by hardware only
      if (i_result_valid) begin
         st_next.regs[ADDR_CONC_H] = i_result[15:8];
         st_next.regs[ADDR_CONC_L] = i_result[7:0];
      end
      if (link.req && !st_reg.ack) begin
         st_next.ack   = 1'b1;
         st_next.rdata = RST_ZERO;
         st_next.rsp   = GSRB_RSP_OK;
         if (is_err) begin
            st_next.rsp = GSRB_RSP_ERR;
         end else if (is_nack) begin
            st_next.rsp = GSRB_RSP_NACK;
         end else if (link.wr) begin
            case (link.addr)
               ADDR_PRODUCT_REVISION_ID, ADDR_CONC_H, ADDR_CONC_L, ADDR_SENSOR_STATUS: ;
               ADDR_SOFT_RST: begin
                  st_next.srst     = link.wdata;
                  st_next.srst_stb = 1'b1;
               end
               ADDR_MEASUREMENT_STATUS: st_next.regs[ADDR_MEASUREMENT_STATUS] =
                  st_reg.regs[ADDR_MEASUREMENT_STATUS] & MASK_MEAS_KEEP;
               // masked write drops unimplemented bits
               // both windows above the map are caught first, so five index bits suffice
               default: st_next.regs[link.addr[4:0]] = link.wdata & wmask(link.addr);
            endcase
         end else begin
            st_next.rdata = read_byte(st_reg.regs, link.addr);
         end
      end
      if (!i_rst_b) begin
         st_next.regs     = reset_bank();
         st_next.pin_s1   = 1'b0;
         st_next.pin_s2   = 1'b0;
         st_next.ack      = 1'b0;
         st_next.rdata    = RST_ZERO;
         st_next.rsp      = GSRB_RSP_OK;
         st_next.srst     = RST_ZERO;
         st_next.srst_stb = 1'b0;
      end
   end

   // reset rides in the next-state logic, so one flop stage holds all state
   always_ff @(posedge i_core_clk) begin
      st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////
   assign link.ack          = st_reg.ack;
   assign link.rdata        = st_reg.rdata;
   assign link.rsp          = st_reg.rsp;
   assign o_measurement_config        = st_reg.regs[ADDR_MEASUREMENT_CONFIG];
   assign o_period          = {st_reg.regs[ADDR_PERIOD_H], st_reg.regs[ADDR_PERIOD_L]};
   assign o_soft_reset_code = st_reg.srst;
   assign o_soft_reset_stb  = st_reg.srst_stb;
endmodule : gsrb_device
`default_nettype wire

// >>> src/gsrb_host.sv
// controller end: AXI4-Lite registers drive byte accesses to the register bank
`timescale 1ns/1ns
`default_nettype none
module gsrb_host (
   // clock and reset
   input  wire logic           i_core_clk,
   input  wire logic           i_rst_b,
   // axi4-lite slave
   input  wire logic [7:0]     i_awaddr,
   input  wire logic           i_awvalid,
   output logic                o_awready,
   input  wire logic [31:0]    i_wdata,
   input  wire logic [3:0]     i_wstrb,
   input  wire logic           i_wvalid,
   output logic                o_wready,
   output logic [1:0]          o_bresp,
   output logic                o_bvalid,
   input  wire logic           i_bready,
   input  wire logic [7:0]     i_araddr,
   input  wire logic           i_arvalid,
   output logic                o_arready,
   output logic [31:0]         o_rdata,
   output logic [1:0]          o_rresp,
   output logic                o_rvalid,
   input  wire logic           i_rready,
   // interrupt
   output logic                o_irq,
   // link to register bank
   gsrb_if.host                link
);
   import gsrb_pkg::*;

   typedef struct packed {
      logic       aw_got, w_got, bvalid, rvalid;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic [31:0] rdata;
      logic [1:0] bresp;
      logic [9:0] cmd;
      logic [7:0] wbyte;
      logic [10:0] result;
      logic [2:0] irq_sts, irq_en;
      logic       req;
   } gsrb_host_t;

   gsrb_host_t st_reg, st_next;
   logic       do_wr;
   logic [31:0] rd;

   ////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      do_wr   = 1'b0;
      rd      = 32'h0000_0000;
      if (i_awvalid && !st_reg.aw_got) begin
         st_next.aw_got = 1'b1;
         st_next.awaddr = i_awaddr;
      end
      if (i_wvalid && !st_reg.w_got) begin
         st_next.w_got = 1'b1;
         st_next.wdata = i_wdata;
         st_next.wstrb = i_wstrb;
      end
      if (st_reg.aw_got && st_reg.w_got && !st_reg.bvalid) begin
         do_wr = 1'b1;
         st_next.aw_got = 1'b0;
         st_next.w_got  = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp  = 2'b00;
      end
      if (st_reg.bvalid && i_bready) st_next.bvalid = 1'b0;
      // upper bits of byte forced zero
      if (do_wr && st_reg.wstrb[0]) begin
         case (st_reg.awaddr)
            CSR_CMD: if (!st_reg.req && st_reg.wstrb[1]) begin
               st_next.cmd = st_reg.wdata[9:0];
               if (st_reg.wdata[CMD_GO_BIT]) begin
                  st_next.req = 1'b1;
                  st_next.result[RES_BUSY_BIT] = 1'b1;
               end
            end
            CSR_WDATA:   st_next.wbyte   = st_reg.wdata[7:0];
            CSR_IRQ_CLR: st_next.irq_sts = st_reg.irq_sts & ~st_reg.wdata[2:0];
            CSR_IRQ_EN:  st_next.irq_en  = st_reg.wdata[2:0];
            default: st_next.bresp = 2'b10;
         endcase
      end
      case (st_reg.awaddr)
         CSR_CMD, CSR_WDATA, CSR_IRQ_CLR, CSR_IRQ_EN: ;
         default: if (do_wr) st_next.bresp = 2'b10;
      endcase
      if (i_arvalid && !st_reg.rvalid) begin
         case (i_araddr)
            CSR_CMD:     rd = {22'h00_0000, st_reg.cmd};
            CSR_WDATA:   rd = {24'h00_0000, st_reg.wbyte};
            CSR_RESULT:  rd = {21'h00_0000, st_reg.result};
            CSR_IRQ_STS: rd = {29'h0000_0000, st_reg.irq_sts};
            CSR_IRQ_EN:  rd = {29'h0000_0000, st_reg.irq_en};
            default:     rd = 32'h0000_0000;
         endcase
         st_next.rvalid = 1'b1;
         st_next.rdata  = rd;
      end
      if (st_reg.rvalid && i_rready) st_next.rvalid = 1'b0;
      if (st_reg.req && link.ack) begin
         st_next.req = 1'b0;
         st_next.result = {link.rsp == GSRB_RSP_NACK, link.rsp == GSRB_RSP_ERR,
                           1'b0, link.rdata};
         // done, comm error, nack; events win over clears
         st_next.irq_sts[0] = 1'b1;
         if (link.rsp == GSRB_RSP_ERR)  st_next.irq_sts[1] = 1'b1;
         if (link.rsp == GSRB_RSP_NACK) st_next.irq_sts[2] = 1'b1;
      end
      if (!i_rst_b) begin
         st_next = '0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      st_reg <= st_next;
   end

   ////////////////////////////////////////////////////////////////
   assign o_awready  = !st_reg.aw_got;
   assign o_wready   = !st_reg.w_got;
   assign o_bvalid   = st_reg.bvalid;
   assign o_bresp    = st_reg.bresp;
   assign o_arready  = !st_reg.rvalid;
   assign o_rvalid   = st_reg.rvalid;
   assign o_rdata    = st_reg.rdata;
   assign o_rresp    = 2'b00;
   assign o_irq      = |(st_reg.irq_sts & st_reg.irq_en);
   assign link.req   = st_reg.req;
   assign link.wr    = st_reg.cmd[CMD_WRITE_BIT];
   assign link.addr  = st_reg.cmd[7:0];
   assign link.wdata = st_reg.wbyte;
endmodule : gsrb_host
`default_nettype wire

// >>> testbench/gsrb_assertions.sv
// checker: timing and answer rules on the byte link of the register bank
`timescale 1ns/1ns
`default_nettype none
module gsrb_assertions
   import gsrb_pkg::*;
(
   // clock and reset
   input wire logic       i_core_clk,
   input wire logic       i_rst_b,
   // link signals
   input wire logic       i_req,
   input wire logic       i_wr,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_ack,
   input wire logic [7:0] i_rdata,
   input wire logic [1:0] i_rsp
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_b);
   logic       take;
   logic       rd;
   logic [7:0] scratch_reg;
   assign take = i_req && !i_ack;
   assign rd   = take && !i_wr;
   // last byte written to the scratch register; cleared with the bank
   always_ff @(posedge i_core_clk) begin
      if (!i_rst_b) begin
         scratch_reg <= 8'h00;
      end else if (take && i_wr && i_addr == ADDR_SCRATCH) begin
         scratch_reg <= i_wdata;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   AST_ACK_ONE: assert property (take |=> i_ack)
      else $error("link answer late");
   AST_ACK_PULSE: assert property (i_ack |=> !i_ack)
      else $error("link answer longer than one cycle");
   AST_ACK_CAUSE: assert property (i_ack |-> $past(i_req))
      else $error("answer without request");
   AST_REQ_HOLD: assert property (take |=> i_req && $stable(i_addr) && $stable(i_wr))
      else $error("request changed before answer");
   AST_REQ_DROP: assert property (i_ack |=> !i_req)
      else $error("request held after answer");
   AST_ERR: assert property (take && i_addr >= ADDR_ERR_FIRST && i_addr <= ADDR_ERR_LAST
      |=> i_rsp == 2'b01)
      else $error("reserved low range without comm error");
   AST_NACK: assert property (take && i_addr > ADDR_ERR_LAST |=> i_rsp == 2'b10)
      else $error("upper range without nack");
   AST_OK: assert property (take && i_addr < ADDR_ERR_FIRST |=> i_rsp == 2'b00)
      else $error("mapped address refused");
   AST_WO_ZERO: assert property (rd && i_addr == ADDR_SOFT_RST |=> i_rdata == 8'h00)
      else $error("write-only register reads nonzero");
   AST_ID_RO: assert property (rd && i_addr == ADDR_PRODUCT_REVISION_ID |=> i_rdata == RST_PRODUCT_REVISION_ID)
      else $error("identity changed");
   AST_CLR_ZERO: assert property (rd && i_addr == ADDR_SENSOR_STATUS |=> i_rdata[2:0] == 3'h0)
      else $error("clear bits read nonzero");
   AST_UNIMPL: assert property (rd && i_addr == ADDR_PERIOD_H |=> i_rdata[7:4] == 4'h0)
      else $error("unimplemented bits read nonzero");
   AST_SCRATCH: assert property (rd && i_addr == ADDR_SCRATCH |=> i_rdata == scratch_reg)
      else $error("scratch byte lost");
   ////////////////////////////////////////////////////////////////////////////
   COV_WRITE: cover property (take && i_wr ##1 i_ack);
   COV_ERR: cover property (take && i_addr == ADDR_ERR_FIRST);
   COV_NACK: cover property (take && i_addr == 8'hff);
endmodule : gsrb_assertions
`default_nettype wire

// >>> testbench/gas_sensor_register_bank_tb.sv
// testbench: both ends joined, driven over axi4-lite and sensor inputs
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module gas_sensor_register_bank_tb;
   import gsrb_pkg::*;
   logic        clk = 1'b0, rst_b = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, cval = 8'h00, cfg, code;
   logic [31:0] wdat = 32'h0000_0000, rdat;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, irq, stb;
   logic [1:0]  bresp, rresp;
   logic        pin = 1, init = 1, terr = 0, serr = 0, rval = 0, cwr = 0;
   logic [15:0] res = 16'h0000, period;
   int          fails = 0, compares = 0, cyc = 0, stbs = 0;
   gsrb_if link_if ();
   gsrb_device gsrb_device_i (.i_core_clk(clk), .i_rst_b(rst_b), .link(link_if.dev),
      .i_pin_level(pin), .i_init_done(init), .i_temp_err(terr), .i_sup_err(serr),
      .i_result_valid(rval), .i_result(res), .i_cfg_wr(cwr), .i_cfg_value(cval),
      .o_measurement_config(cfg), .o_period(period), .o_soft_reset_code(code), .o_soft_reset_stb(stb));
   gsrb_host gsrb_host_i (.i_core_clk(clk), .i_rst_b(rst_b), .i_awaddr(awaddr),
      .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdat), .i_wstrb(4'hf),
      .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid),
      .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid), .o_arready(arready),
      .o_rdata(rdat), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready), .o_irq(irq),
      .link(link_if.host));
   gsrb_assertions gsrb_assertions_i (.i_core_clk(clk), .i_rst_b(rst_b), .i_req(link_if.req),
      .i_wr(link_if.wr), .i_addr(link_if.addr), .i_wdata(link_if.wdata),
      .i_ack(link_if.ack), .i_rdata(link_if.rdata), .i_rsp(link_if.rsp));
   always #5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : stop_test
   // whole run needs little more than a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         fails++;
         stop_test();
      end
   end
   // soft reset strobes seen by the sensor core
   always @(posedge clk) begin
      if (stb === 1'b1) stbs++;
   end
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] br);
      @(posedge clk);
      awaddr <= a; wdat <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      br = bresp;
      bready <= 1'b0;
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clk);
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      d = rdat;
      rready <= 1'b0;
   endtask : axi_rd
   // one byte access; completion is awaited through the done interrupt
   task automatic lnk(input logic w, input logic [7:0] a, input logic [7:0] wd,
                      output logic [10:0] r);
      logic [1:0]  br;
      logic [31:0] d;
      axi_wr(CSR_WDATA, {24'h00_0000, wd}, br);
      axi_wr(CSR_CMD, {22'h00_0000, 1'b1, w, a}, br);
      while (irq !== 1'b1) @(posedge clk);
      axi_rd(CSR_RESULT, d);
      r = d[10:0];
      axi_wr(CSR_IRQ_CLR, 32'h0000_0007, br);
   endtask : lnk
   task automatic wr8(input logic [7:0] a, input logic [7:0] d);
      logic [10:0] r;
      lnk(1'b1, a, d, r);
   endtask : wr8
   task automatic ck8(input logic [7:0] a, input logic [7:0] e);
      logic [10:0] r;
      lnk(1'b0, a, 8'h00, r);
      `CHK(r[7:0], e)
      `CHK(r[10:9], 2'b00)
   endtask : ck8
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_defaults;
      logic [7:0] ex [17] = '{RST_PRODUCT_REVISION_ID, RST_SENSOR_STATUS, 8'h00, RST_PERIOD_L, RST_MEASUREMENT_CONFIG,
         8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, RST_PRES_H, RST_PRES_L, RST_BASE_H,
         RST_BASE_L, 8'h00, 8'h00};
      for (int i = 0; i < NUM_REGS; i++) ck8(i[7:0], ex[i]);
      `CHK(period, 16'h003c)
      `CHK(cfg, RST_MEASUREMENT_CONFIG)
   endtask : t_defaults
   task automatic t_classes;
      wr8(ADDR_PERIOD_H, 8'hf1);
      ck8(ADDR_PERIOD_H, 8'h01);
      wr8(ADDR_PERIOD_L, 8'h0a);
      `CHK(period, 16'h010a)
      wr8(ADDR_MEASUREMENT_CONFIG, 8'h25);
      `CHK(cfg, 8'h25)
      wr8(ADDR_INT_CFG, 8'hea);
      ck8(ADDR_INT_CFG, 8'h0a);
      wr8(ADDR_PRODUCT_REVISION_ID, 8'h00);
      ck8(ADDR_PRODUCT_REVISION_ID, RST_PRODUCT_REVISION_ID);
      wr8(ADDR_CONC_H, 8'h77);
      ck8(ADDR_CONC_H, 8'h00);
      wr8(ADDR_SOFT_RST, 8'hcf);
      `CHK(code, 8'hcf)
      `CHK(stbs, 1)
      ck8(ADDR_SOFT_RST, 8'h00);
      for (int i = 9; i < 16; i++) wr8(i[7:0], i[7:0] ^ 8'h5a);
      for (int i = 9; i < 16; i++) ck8(i[7:0], i[7:0] ^ 8'h5a);
   endtask : t_classes
   task automatic t_hw;
      @(posedge clk);
      res <= 16'hbeef; rval <= 1'b1; cval <= 8'h23; cwr <= 1'b1;
      @(posedge clk);
      rval <= 1'b0; cwr <= 1'b0;
      ck8(ADDR_CONC_H, 8'hbe);
      ck8(ADDR_CONC_L, 8'hef);
      ck8(ADDR_MEASUREMENT_CONFIG, 8'h23);
      pin <= 1'b0;
      ck8(ADDR_SENSOR_STATUS, 8'h80);
      pin <= 1'b1;
   endtask : t_hw
   task automatic t_sticky;
      logic [10:0] r;
      @(posedge clk);
      terr <= 1'b1; serr <= 1'b1;
      @(posedge clk);
      terr <= 1'b0; serr <= 1'b0;
      wr8(ADDR_SENSOR_STATUS, 8'h00);
      ck8(ADDR_SENSOR_STATUS, 8'hf0);
      wr8(ADDR_SENSOR_STATUS, 8'h06);
      ck8(ADDR_SENSOR_STATUS, 8'hc0);
      lnk(1'b0, ADDR_ERR_FIRST, 8'h00, r);
      `CHK(r[10:9], 2'b01)
      lnk(1'b1, ADDR_ERR_LAST, 8'h00, r);
      `CHK(r[10:9], 2'b01)
      ck8(ADDR_SENSOR_STATUS, 8'hc8);
      lnk(1'b1, 8'h15, 8'h00, r);
      `CHK(r[10:9], 2'b10)
      lnk(1'b0, 8'hff, 8'h00, r);
      `CHK(r[10:9], 2'b10)
      wr8(ADDR_SENSOR_STATUS, 8'h01);
      ck8(ADDR_SENSOR_STATUS, 8'hc0);
   endtask : t_sticky
   task automatic t_irq;
      logic [1:0]  br;
      logic [31:0] d;
      axi_wr(CSR_IRQ_EN, 32'h0000_0000, br);
      `CHK(br, 2'b00)
      axi_wr(CSR_CMD, {22'h00_0000, 1'b1, 1'b0, ADDR_SCRATCH}, br);
      d = 32'h0000_0000;
      while (d[0] !== 1'b1) begin
         axi_rd(CSR_IRQ_STS, d);
         `CHK(irq, 1'b0)
      end
      axi_wr(CSR_IRQ_EN, 32'h0000_0001, br);
      axi_rd(CSR_RESULT, d);
      `CHK(d[7:0], 8'h0f ^ 8'h5a)
      `CHK(rresp, 2'b00)
      `CHK(irq, 1'b1)
      axi_wr(CSR_IRQ_CLR, 32'h0000_0007, br);
      axi_rd(CSR_IRQ_STS, d);
      `CHK(d[2:0], 3'h0)
      `CHK(irq, 1'b0)
      axi_wr(8'h40, 32'hffff_ffff, br);
      `CHK(br, 2'b10)
      axi_rd(8'h40, d);
      `CHK(d, 32'h0000_0000)
   endtask : t_irq
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      logic [1:0] br;
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      axi_wr(CSR_IRQ_EN, 32'h0000_0001, br);
      t_defaults();
      t_classes();
      t_hw();
      t_sticky();
      t_irq();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      axi_wr(CSR_IRQ_EN, 32'h0000_0001, br);
      ck8(ADDR_SCRATCH, 8'h00);
      ck8(ADDR_MEASUREMENT_CONFIG, RST_MEASUREMENT_CONFIG);
      stop_test();
   end
endmodule : gas_sensor_register_bank_tb
`default_nettype wire
